// ### core/hhd_pkg.sv
package hhd_pkg;

  // Two serial channels, A is index 0 and B is index 1.
  localparam int unsigned HHD_NCH = 2;
  localparam int unsigned HHD_ADR_W = 7;
  localparam int unsigned HHD_DAT_W = 8;

  // Register offsets on the seven-bit register address.
  localparam logic [6:0] HHD_ADR_DATA_A = 7'h00;
  localparam logic [6:0] HHD_ADR_DATA_B = 7'h01;
  localparam logic [6:0] HHD_ADR_PRIMARY_IRQ_STATUS = 7'h20;
  localparam logic [6:0] HHD_ADR_EXTENDED_IRQ_STATUS = 7'h21;
  localparam logic [6:0] HHD_ADR_CLOCK_MODE = 7'h22;
  localparam logic [6:0] HHD_ADR_TX_BYTE_COUNT_HIGH_REG = 7'h23;
  localparam logic [6:0] HHD_ADR_VERSION_STATUS_REG = 7'h24;

  // Clock mode register: mode A in bits 2..0, mode B in bits 5..3.
  localparam int unsigned HHD_CM_W = 3;
  localparam int unsigned HHD_CM_LSB_A = 0;
  localparam int unsigned HHD_CM_LSB_B = 3;
  localparam logic [7:0] HHD_CLOCK_MODE_RST = 8'h00;

  // Control register: auto start per channel, block size code per channel.
  localparam int unsigned HHD_CTL_AUTO_LSB = 0;
  localparam int unsigned HHD_CTL_BSZ_LSB = 2;
  localparam logic [7:0] HHD_CTL_RST = 8'h00;

  // Status register layouts per channel nibble.
  localparam int unsigned HHD_PIRQ_CAUSES = 3;
  localparam int unsigned HHD_PIRQ_EXT_BIT = 3;
  localparam int unsigned HHD_EIRQ_CAUSES = 3;
  localparam int unsigned HHD_EIRQ_ALT_BIT = 3;
  localparam int unsigned HHD_NIB = 4;

  // Version status: alt levels in bits 1..0, line level in bit 2, version in 7..4.
  localparam int unsigned HHD_VS_LINE_BIT = 2;
  localparam logic [3:0] HHD_VERSION = 4'h1; // Arbitrary value.

  // Block sizes: code 0..3 gives 32, 16, 8 or 4 bytes.
  localparam logic [5:0] HHD_BLOCK_MAX = 6'h20;

  // Clock modes with a special alternative clock role.
  localparam logic [2:0] HHD_CM_RX_STROBE = 3'h1;
  localparam logic [2:0] HHD_CM_FRAME_SYNC = 3'h5;
  localparam logic [2:0] HHD_CM_XTAL_4 = 3'h4;
  localparam logic [2:0] HHD_CM_XTAL_6 = 3'h6;
  localparam logic [2:0] HHD_CM_XTAL_7 = 3'h7;

  typedef enum logic [1:0] {
    HHD_ROLE_CD,
    HHD_ROLE_STROBE,
    HHD_ROLE_FSYNC,
    HHD_ROLE_XTAL
  } hhd_role_t;

  // Decoded functions of one alternative clock input.
  typedef struct packed {
    logic carrier_detect;
    logic rx_enable;
    logic rx_strobe;
    logic frame_sync;
    logic xtal;
  } hhd_alt_fn_t;

endpackage

// ### core/hhd_alt_sel.sv
`timescale 1ns/100ps
module hhd_alt_sel #(
  parameter bit IS_CHAN_A = 1'b1
) (
  // Channel setting.
  input wire logic [2:0] mode_i,
  input wire logic auto_start_i,
  // Sampled pin level.
  input wire logic level_i,
  // Decoded function.
  output hhd_pkg::hhd_role_t role_o,
  output hhd_pkg::hhd_alt_fn_t fn_o
);
  import hhd_pkg::*;

  // Exactly one role is chosen from the clock mode.
  always_comb begin
    unique case (mode_i)
      HHD_CM_RX_STROBE: role_o = HHD_ROLE_STROBE;
      HHD_CM_FRAME_SYNC: role_o = HHD_ROLE_FSYNC;
      HHD_CM_XTAL_4, HHD_CM_XTAL_6, HHD_CM_XTAL_7: begin
        // Only channel A's pin forms the crystal connection.
        role_o = IS_CHAN_A ? HHD_ROLE_XTAL : HHD_ROLE_CD;
      end
      default: role_o = HHD_ROLE_CD;
    endcase
  end

  // Functions not selected see a fixed inactive value, the pin is ignored there.
  always_comb begin
    fn_o.carrier_detect = (role_o == HHD_ROLE_CD) & level_i;
    fn_o.rx_strobe = (role_o == HHD_ROLE_STROBE) & level_i;
    fn_o.frame_sync = (role_o == HHD_ROLE_FSYNC) & level_i;
    fn_o.xtal = (role_o == HHD_ROLE_XTAL);
    // Without auto start the receiver is enabled by software alone.
    fn_o.rx_enable = ~auto_start_i | ((role_o == HHD_ROLE_CD) & level_i);
  end

endmodule

// ### core/hhd_top.sv
`timescale 1ns/100ps
module hhd_top (
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // DMA acknowledges and requests.
  input wire logic dma_ack_chan_a_n_i,
  input wire logic dma_ack_chan_b_n_i,
  output logic [1:0] rx_dma_request_o,
  output logic [1:0] tx_dma_request_o,
  // Open-drain interrupt pin.
  input wire logic irq_n_in_i,
  output logic irq_n_out_o,
  output logic irq_n_oe_o,
  // Alternative clock pins.
  input wire logic [1:0] alt_clock_input_i,
  output hhd_pkg::hhd_alt_fn_t [1:0] alt_fn_o,
  // Engine side: receive queue heads and pops.
  input wire logic [1:0][7:0] rx_data_i,
  input wire logic [1:0] rx_need_i,
  output logic [1:0] rx_pop_o,
  // Engine side: transmit queue loads.
  input wire logic [1:0] tx_need_i,
  output logic [1:0][7:0] tx_data_o,
  output logic [1:0] tx_push_o,
  // Engine side: interrupt events and settings.
  input wire logic [1:0][2:0] irq_evt_i,
  input wire logic [1:0][2:0] ext_evt_i,
  output logic [7:0] clock_mode_o
);
  import hhd_pkg::*;

  logic [7:0] clock_mode_r;
  logic [7:0] ctl_r;
  logic [7:0] rdata_r;
  logic irq_oe_r;
  logic line_r;
  logic [1:0] ack_n;
  logic dma_act;
  logic dma_ch;
  logic reg_rd;
  logic reg_wr;
  logic pirq_rd;
  logic eirq_rd;
  logic [1:0] pop_now;
  logic [1:0] push_now;
  logic [2:0] cause_r [HHD_NCH];
  logic [3:0] ext_r [HHD_NCH];
  logic rx_req_r [HHD_NCH];
  logic rx_hold_r [HHD_NCH];
  logic [5:0] rx_cnt_r [HHD_NCH];
  logic tx_req_r [HHD_NCH];
  logic alt_lvl_r [HHD_NCH];
  logic alt_prev_r [HHD_NCH];
  hhd_alt_fn_t alt_fn_r [HHD_NCH];
  logic rx_pop_r [HHD_NCH];
  logic tx_push_r [HHD_NCH];
  logic [7:0] tx_data_r [HHD_NCH];
  logic [1:0] pend;
  logic [7:0] pirq_view;
  logic [7:0] eirq_view;
  logic [7:0] vstat_view;

  // Acknowledge decode: channel A wins if both are low.
  assign ack_n = {dma_ack_chan_b_n_i, dma_ack_chan_a_n_i};
  assign dma_act = ~ack_n[0] | ~ack_n[1];
  assign dma_ch = ack_n[0];

  // Register accesses only when no acknowledge is active.
  assign reg_rd = rd_i & ~dma_act;
  assign reg_wr = wr_i & ~dma_act;
  assign pirq_rd = reg_rd & (addr_i == HHD_ADR_PRIMARY_IRQ_STATUS);
  assign eirq_rd = reg_rd & (addr_i == HHD_ADR_EXTENDED_IRQ_STATUS);

  // Status views assembled from the sticky bits.
  always_comb begin
    pirq_view = 8'h00;
    eirq_view = 8'h00;
    for (int c = 0; c < HHD_NCH; c++) begin
      pirq_view[c*HHD_NIB +: HHD_PIRQ_CAUSES] = cause_r[c];
      pirq_view[c*HHD_NIB + HHD_PIRQ_EXT_BIT] = |ext_r[c];
      eirq_view[c*HHD_NIB +: HHD_NIB] = ext_r[c];
    end
  end

  // Version status shows pin levels; a crystal pin reads as zero.
  always_comb begin
    vstat_view = {HHD_VERSION, 4'h0};
    for (int c = 0; c < HHD_NCH; c++) begin
      vstat_view[c] = alt_lvl_r[c] & ~alt_fn_r[c].xtal;
    end
    vstat_view[HHD_VS_LINE_BIT] = line_r;
  end

  // Pending interrupt per channel.
  always_comb begin
    for (int c = 0; c < HHD_NCH; c++) begin
      pend[c] = (|cause_r[c]) | (|ext_r[c]);
    end
  end

  // Software settings: clock modes and the control register.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clock_mode_r <= HHD_CLOCK_MODE_RST;
      ctl_r <= HHD_CTL_RST;
    end else if (ce_i) begin
      if (reg_wr && addr_i == HHD_ADR_CLOCK_MODE) begin
        clock_mode_r <= wdata_i;
      end
      if (reg_wr && addr_i == HHD_ADR_TX_BYTE_COUNT_HIGH_REG) begin
        ctl_r <= wdata_i;
      end
    end
  end

  // Read data stands one cycle after the read strobe, zero otherwise.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i) begin
      rdata_r <= 8'h00;
      if (rd_i && dma_act) begin
        // Implicit queue select; an unrequested read returns zero.
        if (rx_req_r[dma_ch]) begin
          rdata_r <= rx_data_i[dma_ch];
        end
      end else if (rd_i) begin
        unique case (addr_i)
          HHD_ADR_DATA_A: rdata_r <= rx_data_i[0];
          HHD_ADR_DATA_B: rdata_r <= rx_data_i[1];
          HHD_ADR_PRIMARY_IRQ_STATUS: rdata_r <= pirq_view;
          HHD_ADR_EXTENDED_IRQ_STATUS: rdata_r <= eirq_view;
          HHD_ADR_CLOCK_MODE: rdata_r <= clock_mode_r;
          HHD_ADR_TX_BYTE_COUNT_HIGH_REG: rdata_r <= ctl_r;
          HHD_ADR_VERSION_STATUS_REG: rdata_r <= vstat_view;
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // Interrupt pin: enable pulls the shared line low, it never drives high.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_oe_r <= 1'b0;
      line_r <= 1'b1;
    end else if (ce_i) begin
      irq_oe_r <= |pend;
      line_r <= irq_n_in_i;
    end
  end

  // Per-channel logic.
  for (genvar c = 0; c < HHD_NCH; c++) begin : g_ch
    logic [5:0] blk_size;
    logic [2:0] mode;
    hhd_role_t role;
    hhd_alt_fn_t fn;
    logic data_adr;

    assign mode = clock_mode_r[(c == 0 ? HHD_CM_LSB_A : HHD_CM_LSB_B) +: HHD_CM_W];
    assign blk_size = HHD_BLOCK_MAX >> ctl_r[HHD_CTL_BSZ_LSB + 2*c +: 2];
    assign data_adr = (addr_i == (c == 0 ? HHD_ADR_DATA_A : HHD_ADR_DATA_B));

    // Queue accesses by acknowledge, or by address when no acknowledge is active.
    assign pop_now[c] = (rd_i & dma_act & (dma_ch == c) & rx_req_r[c]) | (reg_rd & data_adr);
    assign push_now[c] = (wr_i & dma_act & (dma_ch == c) & tx_req_r[c]) | (reg_wr & data_adr);

    hhd_alt_sel #(
      .IS_CHAN_A(c == 0)
    ) u_alt_sel (
      .mode_i(mode),
      .auto_start_i(ctl_r[HHD_CTL_AUTO_LSB + c]),
      .level_i(alt_lvl_r[c]),
      .role_o(role),
      .fn_o(fn)
    );

    // Receive request stays up for a whole block and drops after the last read.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        rx_req_r[c] <= 1'b0;
        rx_hold_r[c] <= 1'b0;
        rx_cnt_r[c] <= 6'h00;
      end else if (ce_i) begin
        if (rx_req_r[c]) begin
          if (pop_now[c] && dma_act) begin
            if (rx_cnt_r[c] + 6'h01 == blk_size) begin
              rx_req_r[c] <= 1'b0;
              rx_cnt_r[c] <= 6'h00;
              rx_hold_r[c] <= 1'b1;
            end else begin
              rx_cnt_r[c] <= rx_cnt_r[c] + 6'h01;
            end
          end
        end else if (rx_hold_r[c]) begin
          // One idle cycle lets the engine update its need after the last pop.
          rx_hold_r[c] <= 1'b0;
        end else if (rx_need_i[c]) begin
          rx_req_r[c] <= 1'b1;
        end
      end
    end

    // Transmit request follows the queue's need, dropped in a loading cycle.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        tx_req_r[c] <= 1'b0;
      end else if (ce_i) begin
        tx_req_r[c] <= tx_need_i[c] & ~push_now[c];
      end
    end

    // Queue strobes and transmit data toward the engine.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        rx_pop_r[c] <= 1'b0;
        tx_push_r[c] <= 1'b0;
        tx_data_r[c] <= 8'h00;
      end else if (ce_i) begin
        rx_pop_r[c] <= pop_now[c];
        tx_push_r[c] <= push_now[c];
        if (push_now[c]) begin
          tx_data_r[c] <= wdata_i;
        end
      end
    end

    // Alternative clock pin sampling and decoded functions.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        alt_lvl_r[c] <= 1'b0;
        alt_prev_r[c] <= 1'b0;
        alt_fn_r[c] <= '0;
      end else if (ce_i) begin
        alt_lvl_r[c] <= alt_clock_input_i[c];
        alt_prev_r[c] <= alt_lvl_r[c];
        alt_fn_r[c] <= fn;
      end
    end

    // Sticky primary causes; a new event wins over the read that clears.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        cause_r[c] <= 3'h0;
      end else if (ce_i) begin
        cause_r[c] <= (pirq_rd ? 3'h0 : cause_r[c]) | irq_evt_i[c];
      end
    end

    // Sticky extended causes, including a carrier detect change.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        ext_r[c] <= 4'h0;
      end else if (ce_i) begin
        ext_r[c] <= (eirq_rd ? 4'h0 : ext_r[c])
                  | {(role == HHD_ROLE_CD) & (alt_lvl_r[c] ^ alt_prev_r[c]), ext_evt_i[c]};
      end
    end

    assign rx_dma_request_o[c] = rx_req_r[c];
    assign tx_dma_request_o[c] = tx_req_r[c];
    assign rx_pop_o[c] = rx_pop_r[c];
    assign tx_push_o[c] = tx_push_r[c];
    assign tx_data_o[c] = tx_data_r[c];
    assign alt_fn_o[c] = alt_fn_r[c];
  end

  // Output drivers; the interrupt pin's data is a constant low level.
  assign rdata_o = rdata_r;
  assign irq_n_out_o = 1'b0;
  assign irq_n_oe_o = irq_oe_r;
  assign clock_mode_o = clock_mode_r;

endmodule

// ### testbench/hhd_top_asserts.sv
`timescale 1ns/100ps
module hhd_top_asserts (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Register and DMA port.
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic dma_ack_chan_a_n_i,
  input wire logic [1:0] rx_dma_request_o,
  input wire logic [1:0] tx_dma_request_o,
  // Interrupt pin and events.
  input wire logic irq_n_out_o,
  input wire logic irq_n_oe_o,
  input wire logic [1:0][2:0] irq_evt_i,
  input wire logic [1:0][2:0] ext_evt_i,
  // Queues and clock pins.
  input wire logic [1:0][7:0] rx_data_i,
  input wire logic [1:0] rx_pop_o,
  input wire logic [1:0] tx_need_i,
  input wire logic [1:0][7:0] tx_data_o,
  input wire logic [1:0] tx_push_o,
  input wire logic [7:0] clock_mode_o,
  input wire hhd_pkg::hhd_alt_fn_t [1:0] alt_fn_o
);
  import hhd_pkg::*;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  // Accepted DMA accesses on channel A, and a settled mode 1 on channel A.
  sequence s_rd_a;
    ce_i && !dma_ack_chan_a_n_i && rd_i && rx_dma_request_o[0];
  endsequence
  sequence s_wr_a;
    ce_i && !dma_ack_chan_a_n_i && wr_i && tx_dma_request_o[0];
  endsequence
  sequence s_mode1;
    (ce_i && clock_mode_o[2:0] == HHD_CM_RX_STROBE) ##1 (clock_mode_o[2:0] == HHD_CM_RX_STROBE);
  endsequence

  a_irq_no_high: assert property (irq_n_out_o == 1'b0)
    else $error("interrupt pin driven high");
  a_irq_set_evt: assert property ((ce_i && |{irq_evt_i, ext_evt_i}) ##1 ce_i |=> irq_n_oe_o)
    else $error("interrupt line not pulled after event");
  a_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read answer");
  a_dma_rd_data: assert property (s_rd_a |=> rx_pop_o[0]
    && rdata_o == $past(rx_data_i[0]))
    else $error("DMA read did not return queue head");
  a_dma_wr_data: assert property (s_wr_a |=> tx_push_o[0]
    && tx_data_o[0] == $past(wdata_i))
    else $error("DMA write did not load queue");
  a_rd_refused: assert property (ce_i && !dma_ack_chan_a_n_i && rd_i && !rx_dma_request_o[0]
    |=> !rx_pop_o[0] && rdata_o == 8'h00)
    else $error("unrequested DMA read served");
  a_tx_req_need: assert property (ce_i && !tx_need_i[0] |=> !tx_dma_request_o[0])
    else $error("transmit request without need");
  a_mode1_role: assert property (s_mode1 |-> !alt_fn_o[0].frame_sync
    && !alt_fn_o[0].xtal && !alt_fn_o[0].carrier_detect)
    else $error("second role active in strobe mode");
  a_b_no_xtal: assert property (!alt_fn_o[1].xtal)
    else $error("channel B pin in crystal role");
endmodule

bind hhd_top hhd_top_asserts u_chk (.clock_i, .reset_n_i, .ce_i, .rd_i, .wr_i, .wdata_i, .rdata_o,
  .dma_ack_chan_a_n_i, .rx_dma_request_o, .tx_dma_request_o, .irq_n_out_o, .irq_n_oe_o, .irq_evt_i,
  .ext_evt_i, .rx_data_i, .rx_pop_o, .tx_need_i, .tx_data_o, .tx_push_o, .clock_mode_o, .alt_fn_o);

// ### testbench/hhd_dma_model.sv
`timescale 1ns/100ps
module hhd_dma_model (
  // Clock, reset and control from the bench.
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic go_i,
  input wire logic ch_i,
  input wire logic slow_i,
  // Requests from the device.
  input wire logic [1:0] rx_req_i,
  input wire logic [1:0] tx_req_i,
  // Bus side.
  output logic ack_a_n_o,
  output logic ack_b_n_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  logic gap_r;

  // Holds the served acknowledge low and strobes while the sampled request is up.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_a_n_o <= 1'b1;
      ack_b_n_o <= 1'b1;
      gap_r <= 1'b0;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      wdata_o <= 8'h00;
    end else begin
      ack_a_n_o <= !(go_i && !ch_i);
      ack_b_n_o <= !(go_i && ch_i);
      gap_r <= slow_i && !gap_r;
      rd_o <= go_i && rx_req_i[ch_i] && !gap_r;
      wr_o <= go_i && !rx_req_i[ch_i] && tx_req_i[ch_i] && !gap_r;
      wdata_o <= wdata_o + 8'h35; // Changes every cycle, so stale data never looks valid.
    end
  end
endmodule

// ### testbench/hhd_top_test.sv
`timescale 1ns/100ps
module hhd_top_test;
  import hhd_pkg::*;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [6:0] addr_i = 7'h00;
  logic t_rd = 1'b0, t_wr = 1'b0, go = 1'b0, ch = 1'b0, slow = 1'b0, p_rd, p_wr, p_a, p_b, rd_i, wr_i;
  logic dma_ack_chan_a_n_i, dma_ack_chan_b_n_i, irq_n_in_i, irq_n_out_o, irq_n_oe_o;
  logic [7:0] t_wdata = 8'h00, p_wdata, wdata_i, rdata_o, clock_mode_o;
  logic [1:0] rx_dma_request_o, tx_dma_request_o, rx_pop_o, tx_push_o;
  logic [1:0] alt_clock_input_i = 2'h0, rx_need_i = 2'h0, tx_need_i = 2'h0;
  logic [1:0][7:0] rx_data_i = 16'h0000, tx_data_o;
  logic [1:0][2:0] irq_evt_i = 6'h00, ext_evt_i = 6'h00;
  hhd_alt_fn_t [1:0] alt_fn_o;
  int n_errors = 0, check_count = 0, cycles = 0, pops = 0, pushes = 0;
  int seed = 32'hF3750FDC;

  hhd_top uut (.*);
  hhd_dma_model u_dma (.clock_i(clock_i), .reset_n_i(reset_n_i), .go_i(go), .ch_i(ch), .slow_i(slow),
    .rx_req_i(rx_dma_request_o), .tx_req_i(tx_dma_request_o), .ack_a_n_o(p_a), .ack_b_n_o(p_b),
    .rd_o(p_rd), .wr_o(p_wr), .wdata_o(p_wdata));

  // The DMA model owns the strobes only while running; the line has a pull-up.
  assign rd_i = t_rd | (go & p_rd);
  assign wr_i = t_wr | (go & p_wr);
  assign wdata_i = go ? p_wdata : t_wdata;
  assign dma_ack_chan_a_n_i = !go | p_a;
  assign dma_ack_chan_b_n_i = !go | p_b;
  assign irq_n_in_i = irq_n_oe_o ? irq_n_out_o : 1'b1;

  always #25 clock_i = ~clock_i;

  // Counts served transfers, feeds random queue heads and cuts a hang short.
  always @(posedge clock_i) begin
    cycles++;
    pops += rx_pop_o[ch];
    pushes += tx_push_o[ch];
    rx_data_i <= 16'($random(seed));
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock_i);
    t_wr <= 1'b1;
    addr_i <= a;
    t_wdata <= d;
    @(posedge clock_i);
    t_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
    @(posedge clock_i);
    t_rd <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    t_rd <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Pin functions {carrier detect, receive enable, strobe, frame sync, crystal}.
  function automatic logic [4:0] exp_fn(logic [2:0] m, logic au, logic lvl, logic a);
    logic xt, cd;
    xt = a && (m == HHD_CM_XTAL_4 || m == HHD_CM_XTAL_6 || m == HHD_CM_XTAL_7);
    cd = !xt && m != HHD_CM_RX_STROBE && m != HHD_CM_FRAME_SYNC;
    return {cd && lvl, !au || (cd && lvl), m == HHD_CM_RX_STROBE && lvl, m == HHD_CM_FRAME_SYNC && lvl, xt};
  endfunction

  // Main sequence.
  initial begin
    int j;
    int k;
    logic [2:0] m;
    logic [4:0] f;
    logic [7:0] d;
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd_reg(HHD_ADR_CLOCK_MODE, HHD_CLOCK_MODE_RST);
    rd_reg(7'h7F, 8'h00);
    chk({7'h00, irq_n_oe_o}, 8'h00);
    // A write while the clock enable is low must leave the clock modes untouched.
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr_reg(HHD_ADR_CLOCK_MODE, 8'h3F);
    ce_i <= 1'b1;
    #1;
    chk(clock_mode_o, HHD_CLOCK_MODE_RST);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      j = 4 * (i % 2) + (i / 2) % 3;
      @(posedge clock_i);
      if (i < 6) irq_evt_i[i % 2][(i / 2) % 3] <= 1'b1;
      else ext_evt_i[i % 2][(i / 2) % 3] <= 1'b1;
      @(posedge clock_i);
      irq_evt_i <= 6'h00;
      ext_evt_i <= 6'h00;
      repeat (2) @(posedge clock_i);
      #1;
      chk({7'h00, irq_n_oe_o}, 8'h01);
      rd_reg(HHD_ADR_PRIMARY_IRQ_STATUS, 8'(i < 6 ? 1 << j : 1 << (4 * (i % 2) + 3)));
      if (i >= 6) rd_reg(HHD_ADR_EXTENDED_IRQ_STATUS, 8'(1 << j));
      repeat (2) @(posedge clock_i);
      #1;
      chk({7'h00, irq_n_oe_o}, 8'h00);
    end
    $display("interrupt test done");
    for (int i = 0; i < 16; i++) begin
      m = 3'(i);
      wr_reg(HHD_ADR_CLOCK_MODE, {2'b00, m, m});
      wr_reg(HHD_ADR_TX_BYTE_COUNT_HIGH_REG, {6'h00, i[3], i[3]});
      alt_clock_input_i <= 2'($random(seed));
      repeat (4) @(posedge clock_i);
      #1;
      f = exp_fn(m, i[3], alt_clock_input_i[0], 1'b1);
      chk(clock_mode_o, {2'b00, m, m});
      chk(8'(alt_fn_o[0]), 8'(f));
      chk(8'(alt_fn_o[1]), 8'(exp_fn(m, i[3], alt_clock_input_i[1], 1'b0)));
      rd_reg(HHD_ADR_VERSION_STATUS_REG, {HHD_VERSION, 1'b0, irq_n_in_i,
        alt_clock_input_i[1], alt_clock_input_i[0] & !f[0]});
    end
    $display("pin role test done");
    for (int c = 0; c < 4; c++) begin
      wr_reg(HHD_ADR_TX_BYTE_COUNT_HIGH_REG, {2'b00, 2'(c), 2'(c), 2'b00});
      @(posedge clock_i);
      ch <= c[1];
      slow <= c[0];
      addr_i <= 7'($random(seed));
      rx_need_i[c[1]] <= 1'b1;
      go <= 1'b1;
      pops = 0;
      k = 0;
      while (rx_dma_request_o[c[1]] !== 1'b1 && k < 20) begin
        @(posedge clock_i);
        #1;
        k++;
      end
      // The need is withdrawn on a clock edge; the request already stands by then.
      @(posedge clock_i);
      rx_need_i <= 2'h0;
      repeat (120) @(posedge clock_i);
      go <= 1'b0;
      #1;
      chk(8'(pops), 8'(32 >> c));
      chk({7'h00, rx_dma_request_o[c[1]]}, 8'h00);
    end
    $display("receive DMA test done");
    for (int c = 0; c < 2; c++) begin
      @(posedge clock_i);
      ch <= c[0];
      slow <= 1'b0;
      tx_need_i[c] <= 1'b1;
      go <= 1'b1;
      pushes = 0;
      repeat (20) @(posedge clock_i);
      tx_need_i <= 2'h0;
      repeat (3) @(posedge clock_i);
      go <= 1'b0;
      #1;
      chk({7'h00, tx_dma_request_o[c]}, 8'h00);
      chk({7'h00, pushes > 0}, 8'h01);
    end
    $display("transmit DMA test done");
    // With no acknowledge active the data addresses load each transmit queue.
    for (int c = 0; c < 2; c++) begin
      d = 8'($random(seed));
      wr_reg(c ? HHD_ADR_DATA_B : HHD_ADR_DATA_A, d);
      #1;
      chk(tx_data_o[c], d);
      chk({7'h00, tx_push_o[c]}, 8'h01);
    end
    $display("register data test done");
    results();
  end
endmodule
